// [hw/crmv_top.sv]
// What this block does
// - A read of the reset register always shows bit 9 set for 20-bit ADC support.
// - A read of the reset register always shows bit 7 set for 20-bit DAC support.
// - A read of the reset register always shows bit 5 set for bass boost, all else zero.
// - The reset register sits at index 0x00 and reads as 02a0.
// - Any write to the reset register returns every register to its default.
// - The volume register sits at index 0x02, defaults to 8000, bit 15 is the mute.
// - Volume bits 13 to 8 are the left attenuation in 1.5 dB steps, zero meaning none.
// - Volume bits 5 to 0 are the right attenuation with the same coding.
// - Read-only registers ignore host writes and read the value the device keeps.
// - Every reserved bit, volume bits 14, 7 and 6 among them, reads zero.
// - The last read asked in a frame is answered in the very next frame; an earlier read in that frame is dropped.
// - Odd or unimplemented indices echo the index and answer zero, never aliased.
`timescale 1ns/1ps
`default_nettype none
module crmv_top import crmv_pkg::*; #(
	parameter crmv_word_type MAKER_CODE = 16'h1234 // arbitrary value
) (
	input  wire logic           sys_clk,
	input  wire logic           rst,
	input  wire logic           frame_start,
	input  wire logic           cmd_valid,
	input  wire logic           cmd_read,
	input  wire crmv_index_type cmd_index,
	input  wire crmv_word_type  cmd_data,
	input  wire crmv_word_type  conv_result_in,
	input  wire crmv_word_type  irq_flags_in,
	input  wire crmv_word_type  clip_flags_in,
	output logic                sts_valid,
	output crmv_index_type      sts_index,
	output crmv_word_type       sts_data,
	output logic                output_mute,
	output logic [ATT_W-1:0]    left_attenuation,
	output logic [ATT_W-1:0]    right_attenuation
);

	crmv_if bus ();

	crmv_store u_crmv_store (
		.sys_clk (sys_clk),
		.rst     (rst),
		.bus     (bus)
	);

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	logic             rw_hit;
	logic [SEL_W-1:0] rw_sel;
	logic             is_write;
	logic             is_read;

	always_comb begin
		rw_hit = 1'b0;
		rw_sel = '0;
		for (int i = 0; i < NUM_RW; i++) begin
			if (cmd_index == RW_INDEX[i]) begin
				rw_hit = 1'b1;
				rw_sel = SEL_W'(i);
			end
		end
	end

	assign is_write       = cmd_valid && !cmd_read;
	assign is_read        = cmd_valid && cmd_read;
	// read-only, odd and unknown indices miss the table and are dropped
	assign bus.wr_en      = is_write && rw_hit;
	assign bus.wr_sel     = rw_sel;
	assign bus.wr_data    = cmd_data;
	assign bus.soft_reset = is_write && cmd_index == IDX_CAP;

	crmv_word_type vol_word;
	assign vol_word          = bus.word[VOL_ENTRY];
	assign output_mute       = vol_word[MUTE_BIT];
	assign left_attenuation  = vol_word[LEFT_LSB +: ATT_W];
	assign right_attenuation = vol_word[RIGHT_LSB +: ATT_W];

	// ------------------------------------------------------------
	// read data selection
	// ------------------------------------------------------------
	crmv_rsp_type   state_d, state_q;
	crmv_index_type pend_idx_d, pend_idx_q;
	crmv_word_type  rd_word;

	always_comb begin
		// exact match only, so odd indices never alias downward
		rd_word = '0;
		unique case (pend_idx_q)
			IDX_CAP:       rd_word = CAP_VALUE;
			IDX_CONV_RES:  rd_word = conv_result_in;
			IDX_IRQ_FLAGS: rd_word = irq_flags_in;
			IDX_CLIP:      rd_word = clip_flags_in;
			IDX_MAKER:     rd_word = MAKER_CODE;
			default: begin
				for (int i = 0; i < NUM_RW; i++) begin
					if (pend_idx_q == RW_INDEX[i]) begin
						rd_word = bus.word[i];
					end
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// response sequencing
	// ------------------------------------------------------------
	logic           sts_valid_d, sts_valid_q;
	crmv_index_type sts_index_d, sts_index_q;
	crmv_word_type  sts_data_d, sts_data_q;
	logic           answering;

	assign answering = frame_start && state_q == RSP_PEND;

	always_comb begin
		state_d     = state_q;
		pend_idx_d  = pend_idx_q;
		sts_valid_d = sts_valid_q;
		sts_index_d = sts_index_q;
		sts_data_d  = sts_data_q;
		if (frame_start) begin
			// status slots hold for a whole frame
			sts_valid_d = answering;
			sts_index_d = pend_idx_q;
			sts_data_d  = answering ? rd_word : '0;
		end
		unique case (state_q)
			RSP_IDLE: state_d = RSP_IDLE;
			RSP_PEND: state_d = frame_start ? RSP_IDLE : RSP_PEND;
			default:  state_d = RSP_IDLE;
		endcase
		// a new request beats the clear; one read per frame, the last one wins
		if (is_read) begin
			state_d    = RSP_PEND;
			pend_idx_d = cmd_index;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q     <= RSP_IDLE;
			pend_idx_q  <= '0;
			sts_valid_q <= 1'b0;
			sts_index_q <= '0;
			sts_data_q  <= '0;
		end else begin
			state_q     <= state_d;
			pend_idx_q  <= pend_idx_d;
			sts_valid_q <= sts_valid_d;
			sts_index_q <= sts_index_d;
			sts_data_q  <= sts_data_d;
		end
	end

	assign sts_valid = sts_valid_q;
	assign sts_index = sts_index_q;
	assign sts_data  = sts_data_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic ans_cap;
	logic ans_vol;
	assign ans_cap = answering && pend_idx_q == IDX_CAP;
	assign ans_vol = answering && pend_idx_q == IDX_VOL;

	adc_cap_bit_a: assert property (ans_cap |=> sts_valid && sts_data[ADC20_BIT])
		else $error("adc capability bit not set");
	dac_cap_bit_a: assert property (ans_cap |=> sts_data[DAC20_BIT] && sts_valid)
		else $error("dac capability bit not set");
	bass_cap_bit_a: assert property (ans_cap |=> sts_data[BASS_BIT] ##1 sts_data[BASS_BIT])
		else $error("bass capability bit not set");
	cap_value_a: assert property (ans_cap |=> sts_data == 16'h02a0 && sts_index == 7'h00)
		else $error("capability word wrong");
	soft_reset_a: assert property (is_write && cmd_index == IDX_CAP
		|=> output_mute && left_attenuation == '0 && right_attenuation == '0)
		else $error("soft reset did not restore volume");
	mute_write_a: assert property (is_write && cmd_index == IDX_VOL
		|=> output_mute == $past(cmd_data[15]))
		else $error("mute not written");
	left_write_a: assert property (is_write && cmd_index == IDX_VOL
		|=> left_attenuation == $past(cmd_data[13:8]))
		else $error("left attenuation not written");
	right_write_a: assert property (is_write && cmd_index == IDX_VOL
		|=> right_attenuation == $past(cmd_data[5:0]))
		else $error("right attenuation not written");
	odd_alias_a: assert property (is_write && cmd_index == (IDX_VOL | 7'h01)
		|=> $stable(vol_word))
		else $error("odd index aliased onto volume");
	ro_read_a: assert property (answering && pend_idx_q == IDX_CONV_RES
		|=> sts_data == $past(conv_result_in))
		else $error("read-only value wrong");
	vol_reserved_a: assert property (ans_vol |=> (sts_data & 16'h40c0) == '0)
		else $error("reserved volume bits not zero");
	next_frame_a: assert property (answering |=> sts_valid && sts_index == $past(pend_idx_q))
		else $error("read not answered in next frame");
	slot_hold_a: assert property (!frame_start |=> $stable(sts_valid) && $stable(sts_data))
		else $error("status slot changed inside frame");
	odd_zero_a: assert property (answering && pend_idx_q[0] |=> sts_data == '0)
		else $error("odd index did not answer zero");
	rsvd_zero_a: assert property (answering && pend_idx_q == IDX_RSVD |=> sts_data == '0)
		else $error("reserved index not zero");
	idle_slot_a: assert property (frame_start && !answering
		|=> !sts_valid && sts_data == '0)
		else $error("empty frame carried data");
	// a later read in the same frame replaces the queued one
	read_queue_a: assert property (is_read |=> state_q == RSP_PEND
		&& pend_idx_q == $past(cmd_index))
		else $error("read request not queued");

	cap_read_c: cover property (is_read && cmd_index == IDX_CAP ##[1:300] frame_start ##1 sts_valid);
	vol_write_c: cover property (is_write && cmd_index == IDX_VOL ##1 !output_mute);
	soft_reset_c: cover property (bus.soft_reset);
	odd_read_c: cover property (answering && pend_idx_q[0]);
	read_frame_c: cover property (is_read && frame_start);

endmodule
`default_nettype wire

// [inc/crmv_pkg.sv]
`default_nettype none
package crmv_pkg;

	typedef logic [15:0] crmv_word_type;
	typedef logic [6:0]  crmv_index_type;

	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	localparam crmv_index_type IDX_CAP       = 7'h00;
	localparam crmv_index_type IDX_VOL       = 7'h02;
	localparam crmv_index_type IDX_FALL_IRQ  = 7'h60;
	localparam crmv_index_type IDX_IRQ_FLAGS = 7'h62;
	localparam crmv_index_type IDX_TOUCH     = 7'h64;
	localparam crmv_index_type IDX_CONV_CTL  = 7'h66;
	localparam crmv_index_type IDX_CONV_RES  = 7'h68;
	localparam crmv_index_type IDX_FEAT_ONE  = 7'h6a;
	localparam crmv_index_type IDX_FEAT_TWO  = 7'h6c;
	localparam crmv_index_type IDX_TEST      = 7'h6e;
	localparam crmv_index_type IDX_CLIP      = 7'h70;
	localparam crmv_index_type IDX_RSVD      = 7'h7a;
	localparam crmv_index_type IDX_MAKER     = 7'h7c;

	// ------------------------------------------------------------
	// capability word
	// ------------------------------------------------------------
	localparam int ADC20_BIT = 9;
	localparam int DAC20_BIT = 7;
	localparam int BASS_BIT  = 5;
	localparam crmv_word_type CAP_VALUE = 16'h02a0;

	// ------------------------------------------------------------
	// output volume word
	// ------------------------------------------------------------
	localparam int MUTE_BIT  = 15;
	localparam int ATT_W     = 6;
	localparam int LEFT_LSB  = 8;
	localparam int RIGHT_LSB = 0;
	localparam crmv_word_type VOL_DEFAULT = 16'h8000;
	localparam crmv_word_type VOL_MASK    = 16'hbf3f;

	// ------------------------------------------------------------
	// writable storage entries, entry 0 is the volume word
	// ------------------------------------------------------------
	localparam int NUM_RW    = 7;
	localparam int SEL_W     = 3;
	localparam int VOL_ENTRY = 0;
	localparam crmv_index_type RW_INDEX [NUM_RW] = '{
		IDX_VOL, IDX_FALL_IRQ, IDX_TOUCH, IDX_CONV_CTL, IDX_FEAT_ONE, IDX_FEAT_TWO, IDX_TEST};
	localparam crmv_word_type RW_DEFAULT [NUM_RW] = '{
		VOL_DEFAULT, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	localparam crmv_word_type RW_MASK [NUM_RW] = '{
		VOL_MASK, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};

	typedef enum logic [1:0] {
		RSP_IDLE = 2'b01,
		RSP_PEND = 2'b10
	} crmv_rsp_type;

endpackage
`default_nettype wire

// [inc/crmv_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface crmv_if import crmv_pkg::*;;
	logic                   wr_en;
	logic [SEL_W-1:0]       wr_sel;
	crmv_word_type          wr_data;
	logic                   soft_reset;
	crmv_word_type          word [NUM_RW];

	modport store (input wr_en, input wr_sel, input wr_data, input soft_reset, output word);
	modport ctrl  (output wr_en, output wr_sel, output wr_data, output soft_reset, input word);
endinterface
`default_nettype wire

// [hw/crmv_store.sv]
`timescale 1ns/1ps
`default_nettype none
module crmv_store import crmv_pkg::*; (
	input  wire logic sys_clk,
	input  wire logic rst,
	crmv_if.store     bus
);

	// ------------------------------------------------------------
	// one word per writable entry
	// ------------------------------------------------------------
	for (genvar i = 0; i < NUM_RW; i++) begin : g_word
		crmv_word_type word_d;
		crmv_word_type word_q;

		always_comb begin
			word_d = word_q;
			if (bus.soft_reset) begin
				word_d = RW_DEFAULT[i];
			end else if (bus.wr_en && bus.wr_sel == SEL_W'(i)) begin
				// reserved bits are dropped here so they always read zero
				word_d = bus.wr_data & RW_MASK[i];
			end
		end

		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				word_q <= RW_DEFAULT[i];
			end else begin
				word_q <= word_d;
			end
		end

		assign bus.word[i] = word_q;
	end

endmodule
`default_nettype wire

// [sim/crmv_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module crmv_host_model import crmv_pkg::*; #(
	parameter int FRAME_LEN = 8
) (
	input  wire logic           sys_clk,
	input  wire logic           rst,
	input  wire logic           sts_valid,
	input  wire crmv_index_type sts_index,
	input  wire crmv_word_type  sts_data,
	output logic                frame_start,
	output logic                cmd_valid,
	output logic                cmd_read,
	output crmv_index_type      cmd_index,
	output crmv_word_type       cmd_data
);
	int cnt;

	initial begin
		cnt <= 0;
		frame_start <= 1'b0;
		cmd_valid <= 1'b0;
		cmd_read <= 1'b0;
		cmd_index <= 7'h00;
		cmd_data <= 16'h0000;
	end

	// ------------------------------------------------------------
	// frame timing
	// ------------------------------------------------------------
	// the link keeps framing through reset, so frames never stop
	always @(posedge sys_clk) begin
		cnt <= (cnt == FRAME_LEN - 1) ? 0 : cnt + 1;
		frame_start <= (cnt == FRAME_LEN - 1);
	end

	// ------------------------------------------------------------
	// command slots
	// ------------------------------------------------------------
	// whole 16-bit words only; slot lines scrambled once released
	task automatic put(input logic rd, input crmv_index_type idx, input crmv_word_type d);
		@(posedge sys_clk iff (cnt == 2 && !rst));
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_index <= idx;
		cmd_data <= d;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		cmd_read <= ~rd;
		cmd_index <= ~idx;
		cmd_data <= ~d;
	endtask

	task automatic rd(input crmv_index_type idx, output logic v, output crmv_index_type i,
		output crmv_word_type d);
		put(1'b1, idx, 16'ha5a5);
		@(posedge sys_clk iff frame_start);
		@(negedge sys_clk);
		v = sts_valid;
		i = sts_index;
		d = sts_data;
	endtask

	// two reads in one frame; only the later one may be answered
	task automatic rd_pair(input crmv_index_type first, input crmv_index_type idx,
		output logic v, output crmv_index_type i, output crmv_word_type d);
		put(1'b1, first, 16'ha5a5);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_read <= 1'b1;
		cmd_index <= idx;
		cmd_data <= 16'ha5a5;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		cmd_read <= 1'b0;
		cmd_index <= ~idx;
		cmd_data <= 16'h5a5a;
		@(posedge sys_clk iff frame_start);
		@(negedge sys_clk);
		v = sts_valid;
		i = sts_index;
		d = sts_data;
	endtask
endmodule
`default_nettype wire

// [sim/crmv_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module crmv_top_tb import crmv_pkg::*;;
	typedef struct {logic wr; crmv_index_type idx; crmv_word_type wd; crmv_word_type ex;} crmv_row_type;

	logic           sys_clk = 1'b0;
	logic           rst = 1'b1;
	logic           frame_start, cmd_valid, cmd_read, sts_valid, output_mute;
	crmv_index_type cmd_index, sts_index;
	crmv_word_type  cmd_data, sts_data;
	crmv_word_type  conv_result_in = 16'h0abc;
	crmv_word_type  irq_flags_in = 16'h0123;
	crmv_word_type  clip_flags_in = 16'h4567;
	logic [ATT_W-1:0] left_attenuation, right_attenuation;
	int             num_errors = 0;
	int             checks = 0;
	crmv_row_type   rows [18] = '{
		'{1'b1, IDX_CAP, 16'hffff, CAP_VALUE}, '{1'b1, IDX_VOL, 16'hffff, VOL_MASK},
		'{1'b1, IDX_CONV_RES, 16'hffff, 16'h0abc}, '{1'b1, IDX_IRQ_FLAGS, 16'hffff, 16'h0123},
		'{1'b1, IDX_CLIP, 16'hffff, 16'h4567}, '{1'b1, IDX_MAKER, 16'hffff, 16'h5a5a},
		'{1'b1, IDX_RSVD, 16'hffff, 16'h0000}, '{1'b1, IDX_FALL_IRQ, 16'h1111, 16'h1111},
		'{1'b1, IDX_TOUCH, 16'h2222, 16'h2222}, '{1'b1, IDX_CONV_CTL, 16'h3333, 16'h3333},
		'{1'b1, IDX_FEAT_ONE, 16'h4444, 16'h4444}, '{1'b1, IDX_FEAT_TWO, 16'h5555, 16'h5555},
		'{1'b1, IDX_TEST, 16'h6666, 16'h6666}, '{1'b1, IDX_VOL, 16'h1f05, 16'h1f05},
		'{1'b1, 7'h03, 16'hffff, 16'h0000}, '{1'b0, IDX_VOL, 16'h0000, 16'h1f05},
		'{1'b1, 7'h7e, 16'hffff, 16'h0000}, '{1'b0, IDX_FALL_IRQ, 16'h0000, 16'h1111}};

	always #2 sys_clk = ~sys_clk;

	crmv_top #(.MAKER_CODE(16'h5a5a)) u_crmv_top ( // arbitrary value
		.sys_clk(sys_clk), .rst(rst), .frame_start(frame_start), .cmd_valid(cmd_valid),
		.cmd_read(cmd_read), .cmd_index(cmd_index), .cmd_data(cmd_data),
		.conv_result_in(conv_result_in), .irq_flags_in(irq_flags_in),
		.clip_flags_in(clip_flags_in), .sts_valid(sts_valid), .sts_index(sts_index),
		.sts_data(sts_data), .output_mute(output_mute), .left_attenuation(left_attenuation),
		.right_attenuation(right_attenuation));

	crmv_host_model u_crmv_host_model (
		.sys_clk(sys_clk), .rst(rst), .sts_valid(sts_valid), .sts_index(sts_index),
		.sts_data(sts_data), .frame_start(frame_start), .cmd_valid(cmd_valid),
		.cmd_read(cmd_read), .cmd_index(cmd_index), .cmd_data(cmd_data));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input crmv_word_type got, input crmv_word_type ex);
		checks++;
		if (got !== ex) begin
			num_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, ex);
		end
	endtask

	task automatic rd_chk(input crmv_index_type idx, input crmv_word_type ex);
		logic           v;
		crmv_index_type i;
		crmv_word_type  d;
		u_crmv_host_model.rd(idx, v, i, d);
		check({15'h0000, v}, 16'h0001);
		check({9'h000, i}, {9'h000, idx});
		check(d, ex);
	endtask

	task automatic ports_chk(input crmv_word_type ex);
		check({output_mute, 1'b0, left_attenuation, 2'b00, right_attenuation}, ex);
	endtask

	task automatic pair_chk();
		logic           v;
		crmv_index_type i;
		crmv_word_type  d;
		u_crmv_host_model.rd_pair(IDX_CAP, IDX_MAKER, v, i, d);
		check({15'h0000, v}, 16'h0001);
		check({9'h000, i}, {9'h000, IDX_MAKER});
		check(d, 16'h5a5a);
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
	endtask

	task automatic wrap_up();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// watchdog: tests need well under 2000 cycles
	// ------------------------------------------------------------
	initial begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		do_reset();
		foreach (rows[n]) begin
			if (rows[n].wr)
				u_crmv_host_model.put(1'b0, rows[n].idx, rows[n].wd);
			rd_chk(rows[n].idx, rows[n].ex);
			$display("row %0d done", n);
		end
		ports_chk(16'h1f05);
		@(posedge sys_clk iff frame_start);
		@(negedge sys_clk);
		check({15'h0000, sts_valid}, 16'h0000);
		check(sts_data, 16'h0000);
		$display("idle frame test done");
		u_crmv_host_model.put(1'b0, IDX_CAP, 16'h1234);
		@(negedge sys_clk);
		ports_chk(VOL_DEFAULT);
		rd_chk(IDX_FALL_IRQ, 16'h0000);
		rd_chk(IDX_TEST, 16'h0000);
		rd_chk(IDX_VOL, VOL_DEFAULT);
		$display("soft reset test done");
		pair_chk();
		$display("read order test done");
		u_crmv_host_model.put(1'b0, IDX_VOL, 16'h3f3f);
		do_reset();
		@(negedge sys_clk);
		ports_chk(VOL_DEFAULT);
		check(sts_data, 16'h0000);
		rd_chk(IDX_VOL, VOL_DEFAULT);
		$display("hard reset test done");
		wrap_up();
	end
endmodule
`default_nettype wire
